// ---- rtl/bridge_config_command_regs.sv ----
// identification, command and status words of the bridge configuration header
//
// Summary of operation
// - offset 00h low word always reads the maker code; writes ignored.
// - offset 02h word always reads this bridge's part code.
// - command bits 15 to 11 always read zero.
// - command bit 10 interrupt disable reads zero; bridge raises no interrupts.
// - command bit 9 back-to-back gate always reads zero.
// - bit 8 error report gate, read/write, reset zero, gates error messages upstream.
// - command bit 7 stepping gate hardwired zero.
// - bit 6 parity gate, reset zero; poisoned tlp sets parity flag only when set.
// - poisoned tlp forwarded downstream with bad parity only when its decode gate accepts it.
// - command bit 5 palette snoop gate always reads zero.
// - bit 4 promote gate turns memory writes into write-and-invalidate.
// - command bit 3 special cycle gate always reads zero.
// - bit 2 initiate gate lets bridge start upstream transactions.
// - with initiate gate clear, secondary memory and io transactions are ignored.
// - with memory decode clear, downstream memory requests get unsupported request.
// - with memory decode set, downstream memory requests are accepted and forwarded.
// - with port decode clear, downstream io requests get unsupported request.
// - with port decode set, downstream io requests are accepted and forwarded.
// - parity flag bit 8 sets on poisoned completion or accepted poisoned write when gate set.
// - fault flag bit 14 sets when an error message goes out with gate set.
`timescale 1ns/100ps
`include "bridge_cfg_params.svh"

module bridge_config_command_regs #(
    parameter logic [15:0] MAKER_CODE = 16'h1234,  // arbitrary value
    parameter logic [15:0] PART_CODE  = 16'h5678   // arbitrary value
) (
    input  wire logic                  sys_clk_i,          // system clock
    input  wire logic                  rst_n_i,            // sync reset, active low
    input  wire bridge_cfg_pkg::cfg_req_t  cfg_req_i,      // configuration access
    output logic [31:0]                cfg_rdata_o,        // read data
    output logic                       cfg_ack_o,          // access done pulse
    input  wire bridge_cfg_pkg::down_req_t down_req_i,     // downstream request
    output bridge_cfg_pkg::down_rsp_t  down_rsp_o,         // downstream answer
    input  wire logic                  sec_txn_i,          // secondary mem/io transaction
    output logic                       sec_respond_o,      // respond on secondary bus
    output logic                       upstream_init_ok_o, // may initiate upstream
    input  wire logic                  sec_serr_i,         // serr seen on secondary
    output logic                       err_msg_o,          // send error message pulse
    input  wire logic                  poison_cpl_i,       // poisoned completion received
    output logic [15:0]                command_o,          // command word
    output logic [15:0]                status_o            // status word
);

    //------------------------------------------------------------
    // command and status storage
    //------------------------------------------------------------
    logic [15:0] command;
    logic [15:0] status;
    logic [15:0] next_command;
    logic [15:0] next_status;

    wire         error_report_gate        = command[`CMD_BIT_ERROR_RPT];
    wire         parity_report_gate       = command[`CMD_BIT_PARITY_RPT];
    wire         write_invalidate_promote = command[`CMD_BIT_WR_INV];
    wire         upstream_initiate_gate   = command[`CMD_BIT_INITIATE];
    wire         mem_decode_gate          = command[`CMD_BIT_MEM_DEC];
    wire         port_decode_gate         = command[`CMD_BIT_PORT_DEC];

    //------------------------------------------------------------
    // access decode
    //------------------------------------------------------------
    wire         hit_cmd    = cfg_req_i.valid && (cfg_req_i.addr == `CFG_OFS_CMD_STAT);
    wire         wr_cmd     = hit_cmd && cfg_req_i.write;
    wire [15:0]  cmd_lanes  = {{8{cfg_req_i.be[1]}}, {8{cfg_req_i.be[0]}}};
    wire [15:0]  stat_lanes = {{8{cfg_req_i.be[3]}}, {8{cfg_req_i.be[2]}}};
    wire [15:0]  cmd_wmask  = cmd_lanes & `CMD_WRITABLE_MASK;
    // write-one-to-clear on the status flags
    wire [15:0]  stat_clr   = (wr_cmd ? (cfg_req_i.wdata[31:16] & stat_lanes) : 16'h0000)
                              & `STAT_CLEAR_MASK;

    // fixed bits are masked out of the write, so they stay zero
    assign next_command = wr_cmd ? ((command & ~cmd_wmask) | (cfg_req_i.wdata[15:0] & cmd_wmask))
                                 : command;

    //------------------------------------------------------------
    // downstream requests
    //------------------------------------------------------------
    wire         mem_ok     = down_req_i.is_mem && mem_decode_gate;
    wire         io_ok      = down_req_i.is_io && port_decode_gate;
    wire         req_ok     = mem_ok || io_ok;
    wire         poison_wr  = down_req_i.valid && down_req_i.poisoned && down_req_i.write && req_ok;
    wire         poison_rx  = down_req_i.valid && down_req_i.poisoned;

    //------------------------------------------------------------
    // status flag events, set wins over clear
    //------------------------------------------------------------
    wire         parity_evt = parity_report_gate && (poison_cpl_i || poison_wr);
    wire         fault_evt  = sec_serr_i && error_report_gate;
    wire [15:0]  stat_set   = {poison_rx || poison_cpl_i, fault_evt, 5'b0_0000, parity_evt, 8'h00};

    assign next_status = (status & ~stat_clr) | stat_set;

    //------------------------------------------------------------
    // read data and registers
    //------------------------------------------------------------
    logic [31:0] next_rdata;
    assign next_rdata = !cfg_req_i.valid || cfg_req_i.write ? 32'h0000_0000 :
                        (cfg_req_i.addr == `CFG_OFS_ID_WORD) ? {PART_CODE, MAKER_CODE} :
                        hit_cmd ? {status, command} : 32'h0000_0000;

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            command     <= `CMD_RESET;
            status      <= `STAT_RESET;
            cfg_rdata_o <= 32'h0000_0000;
            cfg_ack_o   <= 1'b0;
            down_rsp_o  <= '0;
            err_msg_o   <= 1'b0;
        end else begin
            command     <= next_command;
            status      <= next_status;
            cfg_rdata_o <= next_rdata;
            cfg_ack_o   <= cfg_req_i.valid;
            err_msg_o   <= fault_evt;
            down_rsp_o.valid      <= down_req_i.valid;
            down_rsp_o.accept     <= down_req_i.valid && req_ok;
            down_rsp_o.status     <= (down_req_i.valid && !req_ok) ? `CPL_UNSUPPORTED : `CPL_OK;
            down_rsp_o.forward    <= down_req_i.valid && req_ok;
            down_rsp_o.bad_parity <= down_req_i.valid && req_ok && down_req_i.poisoned;
            down_rsp_o.write_inv  <= down_req_i.valid && mem_ok && down_req_i.write
                                     && write_invalidate_promote;
        end
    end

    assign sec_respond_o      = sec_txn_i && upstream_initiate_gate;
    assign upstream_init_ok_o = upstream_initiate_gate;
    assign command_o          = command;
    assign status_o           = status;

    //------------------------------------------------------------
    // checks
    //------------------------------------------------------------
    sequence s_cmd_write;
        cfg_req_i.valid && cfg_req_i.write && cfg_req_i.addr == `CFG_OFS_CMD_STAT && cfg_req_i.be[1:0] == 2'b11;
    endsequence

    a_fixed_bits_zero: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        command[15:9] == 7'h00 && command[7] == 1'b0 && command[5] == 1'b0 && command[3] == 1'b0)
        else $error("fixed command bits not zero");
    a_id_read_value: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        cfg_req_i.valid && !cfg_req_i.write && cfg_req_i.addr == `CFG_OFS_ID_WORD
        |=> cfg_rdata_o == {PART_CODE, MAKER_CODE})
        else $error("id word read wrong");
    a_cmd_write_takes: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        s_cmd_write |=> command == ($past(cfg_req_i.wdata[15:0]) & `CMD_WRITABLE_MASK))
        else $error("command write not stored as masked");
    a_mem_unsupported: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        down_req_i.valid && down_req_i.is_mem && !down_req_i.is_io && !mem_decode_gate
        |=> down_rsp_o.valid && down_rsp_o.status == `CPL_UNSUPPORTED && !down_rsp_o.forward)
        else $error("memory request not refused");
    a_io_accepted: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        down_req_i.valid && down_req_i.is_io && port_decode_gate
        |=> down_rsp_o.accept && down_rsp_o.status == `CPL_OK)
        else $error("io request not accepted");
    a_poison_forward: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        down_req_i.valid && down_req_i.poisoned && req_ok |=> down_rsp_o.bad_parity)
        else $error("poisoned tlp forwarded without bad parity");
    a_parity_gated: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        !$past(status[`STAT_BIT_PARITY_FLAG]) && status[`STAT_BIT_PARITY_FLAG]
        |-> $past(parity_report_gate))
        else $error("parity flag set while gate clear");
    a_fault_flag_set: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        err_msg_o |-> status[`STAT_BIT_FAULT_FLAG] && $past(error_report_gate))
        else $error("error message without fault flag");
    a_secondary_block: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        !upstream_initiate_gate |-> !sec_respond_o)
        else $error("secondary response while initiate gate clear");
    a_promote_write: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        down_req_i.valid && down_req_i.is_mem && down_req_i.write && mem_decode_gate && !write_invalidate_promote
        |=> !down_rsp_o.write_inv)
        else $error("promotion while gate clear");
    a_port_unsupported: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        down_req_i.valid && down_req_i.is_io && !down_req_i.is_mem && !port_decode_gate
        |=> down_rsp_o.valid && down_rsp_o.status == `CPL_UNSUPPORTED && !down_rsp_o.accept)
        else $error("io request not refused");
    a_mem_accepted: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        down_req_i.valid && down_req_i.is_mem && mem_decode_gate
        |=> down_rsp_o.accept && down_rsp_o.forward && down_rsp_o.status == `CPL_OK)
        else $error("memory request not accepted");

endmodule // bridge_config_command_regs

// ---- rtl/bridge_cfg_params.svh ----
// offsets, field positions and reset values of the bridge configuration front registers
`ifndef BRIDGE_CFG_PARAMS_SVH
`define BRIDGE_CFG_PARAMS_SVH

`define CFG_OFS_ID_WORD       8'h00
`define CFG_OFS_CMD_STAT      8'h04
`define CFG_OFS_CTRL_DIAG_0   8'hc0
`define CFG_OFS_CTRL_DIAG_1   8'hc4
`define CFG_OFS_CTRL_DIAG_2   8'hc8
`define CFG_OFS_SUBSYS_ACCESS 8'hd0
`define CFG_OFS_GEN_CONTROL   8'hd4
`define CFG_OFS_ARBITER       8'hdc

`define CMD_BIT_PORT_DEC      0
`define CMD_BIT_MEM_DEC       1
`define CMD_BIT_INITIATE      2
`define CMD_BIT_WR_INV        4
`define CMD_BIT_PARITY_RPT    6
`define CMD_BIT_ERROR_RPT     8
`define CMD_RESET             16'h0000
`define CMD_WRITABLE_MASK     16'h0157

`define STAT_BIT_PARITY_FLAG  8
`define STAT_BIT_FAULT_FLAG   14
`define STAT_BIT_DET_PARITY   15
`define STAT_RESET            16'h0010
`define STAT_CLEAR_MASK       16'hc100

`define CPL_OK                2'h0
`define CPL_UNSUPPORTED       2'h1
`endif

// ---- rtl/bridge_cfg_pkg.sv ----
// types shared by the bridge configuration front registers
package bridge_cfg_pkg;
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [7:0]  addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } cfg_req_t;

    typedef struct packed {
        logic        valid;
        logic        is_mem;
        logic        is_io;
        logic        poisoned;
        logic        write;
    } down_req_t;

    typedef struct packed {
        logic        valid;
        logic        accept;
        logic [1:0]  status;
        logic        forward;
        logic        bad_parity;
        logic        write_inv;
    } down_rsp_t;
endpackage

// ---- testbench/host_cfg_model.sv ----
// host side model issuing configuration reads and writes to the bridge
`timescale 1ns/100ps
module host_cfg_model (
    input  wire logic                 sys_clk_i,   // system clock
    input  wire logic [31:0]          cfg_rdata_i, // read data
    input  wire logic                 cfg_ack_i,   // access done pulse
    output bridge_cfg_pkg::cfg_req_t  cfg_req_o,   // configuration access
    output logic                      fail_o       // no answer in time
);
    initial begin
        cfg_req_o = '0;
        fail_o    = 1'b0;
    end
    task automatic access(input logic wr, input logic [7:0] ad, input logic [3:0] b,
                          input logic [31:0] wd, output logic [31:0] rd);
        @(posedge sys_clk_i) #1;
        cfg_req_o = '{valid: 1'b1, write: wr, addr: ad, be: b, wdata: wd};
        @(posedge sys_clk_i) #1;
        // released fields show the inverse, never the old value
        cfg_req_o = '{valid: 1'b0, write: ~wr, addr: ~ad, be: ~b, wdata: ~wd};
        rd = 32'hxxxx_xxxx;
        for (int n = 0; n < 4; n++) begin
            if (cfg_ack_i === 1'b1) begin
                rd = cfg_rdata_i;
                return;
            end
            @(posedge sys_clk_i) #1;
        end
        fail_o = 1'b1;
    endtask
endmodule // host_cfg_model

// ---- testbench/bridge_config_command_regs_tb.sv ----
// self-checking bench for the bridge configuration front registers
`timescale 1ns/100ps
module bridge_config_command_regs_tb;
    localparam logic [15:0] MK = 16'ha5c3; // arbitrary value
    localparam logic [15:0] PT = 16'h3c5a; // arbitrary value
    typedef struct packed {logic wr; logic [7:0] ad; logic [3:0] b; logic [31:0] wd; logic [31:0] exp;} row_t;
    logic                      sys_clk_i = 1'b0;
    logic                      rst_n_i   = 1'b0;
    bridge_cfg_pkg::cfg_req_t  cfg_req;
    logic [31:0]               cfg_rdata_o;
    logic                      cfg_ack_o;
    bridge_cfg_pkg::down_req_t down_req_i = '0;
    bridge_cfg_pkg::down_rsp_t down_rsp_o;
    logic                      sec_txn_i = 1'b0, sec_serr_i = 1'b0, poison_cpl_i = 1'b0;
    logic                      sec_respond_o, upstream_init_ok_o, err_msg_o, fail;
    logic [15:0]               command_o, status_o;
    logic [31:0]               rd;
    int                        err_total = 0, n_tests = 0;
    row_t rows [10] = '{
        '{1'b0, 8'h00, 4'hf, 32'h0000_0000, {PT, MK}},
        '{1'b0, 8'h04, 4'hf, 32'h0000_0000, 32'h0010_0000},
        '{1'b1, 8'h04, 4'h3, 32'hffff_ffff, 32'h0000_0000},
        '{1'b0, 8'h04, 4'hf, 32'h0000_0000, 32'h0010_0157},
        '{1'b1, 8'h00, 4'hf, 32'hffff_ffff, 32'h0000_0000},
        '{1'b0, 8'h00, 4'hf, 32'h0000_0000, {PT, MK}},
        '{1'b0, 8'hc0, 4'hf, 32'h0000_0000, 32'h0000_0000},
        '{1'b1, 8'h04, 4'h3, 32'h0000_0000, 32'h0000_0000},
        '{1'b0, 8'h04, 4'hf, 32'h0000_0000, 32'h0010_0000},
        '{1'b1, 8'h04, 4'h3, 32'h0000_0157, 32'h0000_0000}};
    initial forever #5 sys_clk_i = ~sys_clk_i;
    bridge_config_command_regs #(.MAKER_CODE(MK), .PART_CODE(PT)) bridge_config_command_regs_i (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .cfg_req_i(cfg_req), .cfg_rdata_o(cfg_rdata_o),
        .cfg_ack_o(cfg_ack_o), .down_req_i(down_req_i), .down_rsp_o(down_rsp_o), .sec_txn_i(sec_txn_i),
        .sec_respond_o(sec_respond_o), .upstream_init_ok_o(upstream_init_ok_o), .sec_serr_i(sec_serr_i),
        .err_msg_o(err_msg_o), .poison_cpl_i(poison_cpl_i), .command_o(command_o), .status_o(status_o));
    host_cfg_model host_cfg_model_i (.sys_clk_i(sys_clk_i), .cfg_rdata_i(cfg_rdata_o), .cfg_ack_i(cfg_ack_o),
        .cfg_req_o(cfg_req), .fail_o(fail));
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // one downstream request with side events, answer checked one cycle later
    task automatic step(input logic m, io, p, w, sv, cp, input logic [6:0] rsp, input logic msg,
                        input logic [15:0] st);
        @(posedge sys_clk_i) #1;
        down_req_i = '{valid: 1'b1, is_mem: m, is_io: io, poisoned: p, write: w};
        sec_serr_i = sv;
        poison_cpl_i = cp;
        @(posedge sys_clk_i) #1;
        down_req_i = '{valid: 1'b0, is_mem: ~m, is_io: ~io, poisoned: ~p, write: ~w};
        sec_serr_i = 1'b0;
        poison_cpl_i = 1'b0;
        chk("down_rsp", {25'h0, down_rsp_o}, {25'h0, rsp});
        chk("err_msg", {31'h0, err_msg_o}, {31'h0, msg});
        chk("status", {16'h0, status_o}, {16'h0, st});
    endtask
    initial begin
        repeat (2) @(posedge sys_clk_i);
        #1 rst_n_i = 1'b1;
        foreach (rows[i]) begin
            host_cfg_model_i.access(rows[i].wr, rows[i].ad, rows[i].b, rows[i].wd, rd);
            if (fail) begin
                err_total++;
                tally_and_finish();
            end
            if (!rows[i].wr) chk("cfg_rdata", rd, rows[i].exp);
        end
        sec_txn_i = 1'b1;
        #1 chk("sec_respond", {30'h0, sec_respond_o, upstream_init_ok_o}, 32'h0000_0003);
        step(1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 7'h67, 1'b0, 16'h8110);
        step(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 7'h64, 1'b1, 16'hc110);
        @(posedge sys_clk_i) #1 rst_n_i = 1'b0;
        repeat (2) @(posedge sys_clk_i);
        #1 rst_n_i = 1'b1;
        chk("cmd_stat", {status_o, command_o}, 32'h0010_0000);
        chk("sec_respond", {30'h0, sec_respond_o, upstream_init_ok_o}, 32'h0000_0000);
        step(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 7'h48, 1'b0, 16'h8010);
        step(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 7'h48, 1'b0, 16'h8010);
        host_cfg_model_i.access(1'b1, 8'h04, 4'hf, 32'hc100_0040, rd);
        host_cfg_model_i.access(1'b0, 8'h04, 4'hf, 32'h0000_0000, rd);
        chk("cmd_stat_clear", rd, 32'h0010_0040);
        step(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 7'h48, 1'b0, 16'h8110);
        if (fail) err_total++;
        tally_and_finish();
    end
endmodule // bridge_config_command_regs_tb
